// File: design/uptfc_top.sv
// Serial port with task-driven transmitter, clear-to-send pause and pin routing.
//
// How it works
// - Parity is generated on transmit, checked on receive, as a ninth bit.
// - Every transmitted frame ends with exactly one stop bit.
// - Data moves through one transmit and one receive data register only.
// - Each of the four serial signals goes to the pin its select picks.
// - A disconnected select neither drives nor samples any pin.
// - Pin selects act only while enabled; disabled, all pins are released.
// - Clear-to-send and request-to-send are active low.
// - Transmission starts only after the transmit begin task.
// - While started, a transmit data write sends that byte; a second write before it starts replaces it.
// - A byte done event rises after each byte completes.
// - The transmit halt task ends transmission immediately.
// - With flow control, sending pauses while clear-to-send is deasserted.
// - A byte in progress always finishes before a flow control pause.
// - Disabling leaves configuration registers unchanged.
// - Without flow control, clear-to-send counts as always asserted.
// - Suspend finishes the current byte then halts; begin task resumes.
// - Parity, when enabled, is even in both directions.
// - Separate events mark clear-to-send falling and rising.
`timescale 1ns/1ns
module uptfc_top #(
  parameter int NUM_PINS = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input uptfc_pkg::uptfc_avreq_t avs_req_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  output logic [NUM_PINS-1:0] pin_out_o,
  output logic [NUM_PINS-1:0] pin_oe_o
);
  import uptfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [ENABLE_W-1:0] enable_reg, enable_next;
  logic [31:0] psel_rts_reg, psel_rts_next;
  logic [31:0] psel_tx_reg, psel_tx_next;
  logic [31:0] psel_cts_reg, psel_cts_next;
  logic [31:0] psel_rx_reg, psel_rx_next;
  logic [1:0] config_reg, config_next;
  logic [BAUD_W-1:0] baud_reg, baud_next;
  logic [NUM_EV-1:0] ev_reg, ev_next, ev_set, ev_clr;
  logic [2:0] errsrc_reg, errsrc_next, err_set;
  logic [DATA_BITS-1:0] rxdata_reg, rxdata_next;
  logic rx_on_reg, rx_on_next;
  logic cts_prev_reg, cts_prev_next;
  uptfc_txst_t txst_reg, txst_next;
  logic [FRAME_MAX-1:0] sh_reg, sh_next;
  logic [BAUD_W-1:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic pend_reg, pend_next;
  logic [DATA_BITS-1:0] pdata_reg, pdata_next;
  logic susp_reg, susp_next;
  logic [NUM_PINS-1:0] pout_reg, pout_next, poe_reg, poe_next;
  logic [NUM_PINS-1:0] pin_s;
  logic en, hwfc, par_en, wr_take, rd_take, cts_n, cts_ok, rx_line, tx_line, rts_n;
  logic [3:0] last_bit;
  logic [DATA_BITS-1:0] rx_byte;
  logic rx_valid, rx_perr, rx_ferr;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Picks the level of the selected pin; a disconnected signal reads idle high.
  function automatic logic pin_pick(input logic [31:0] psel,
                                    input logic [NUM_PINS-1:0] vec);
    if (psel[PSEL_CONNECT_BIT])
      return 1'b1;
    else
      return vec[psel[PSEL_PIN_W-1:0]];
  endfunction

  // True when a select routes its signal to the given pin.
  function automatic logic pin_hit(input logic [31:0] psel, input int p);
    return !psel[PSEL_CONNECT_BIT] && (psel[PSEL_PIN_W-1:0] == PSEL_PIN_W'(p));
  endfunction

  // Pin levels cross into the clock domain through two flip-flops.
  uptfc_sync #(.W(NUM_PINS)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pin_in_i),
    .q_o(pin_s)
  );

  // Inputs are sampled only from connected pins of an enabled port.
  assign en = (enable_reg == ENABLE_ON);
  assign hwfc = config_reg[CFG_HWFC_BIT];
  assign par_en = config_reg[CFG_PARITY_BIT];
  assign cts_n = en ? pin_pick(psel_cts_reg, pin_s) : 1'b1;
  assign rx_line = en ? pin_pick(psel_rx_reg, pin_s) : 1'b1;
  assign cts_ok = !hwfc || !cts_n;

  uptfc_rx u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(rx_on_reg && en),
    .line_i(rx_line),
    .parity_en_i(par_en),
    .baud_div_i(baud_reg),
    .byte_o(rx_byte),
    .byte_valid_o(rx_valid),
    .parity_err_o(rx_perr),
    .frame_err_o(rx_ferr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and registers.

  // A request is answered one cycle after it appears; writes land at the answer edge.
  assign rd_take = avs_req_i.read && wait_reg;
  assign wr_take = avs_req_i.write && !wait_reg;

  always_comb
  begin
    wait_next = !((avs_req_i.read || avs_req_i.write) && wait_reg);
    rdata_next = rdata_reg;
    enable_next = enable_reg;
    psel_rts_next = psel_rts_reg;
    psel_tx_next = psel_tx_reg;
    psel_cts_next = psel_cts_reg;
    psel_rx_next = psel_rx_reg;
    config_next = config_reg;
    baud_next = baud_reg;
    ev_clr = '0;
    if (rd_take)
    begin
      rdata_next = '0;
      for (int i = 0; i < NUM_EV; i++)
      begin
        if (avs_req_i.address == EV_OFFS[i])
          rdata_next = {31'h0000_0000, ev_reg[i]};
      end
      case (avs_req_i.address)
        OFF_ERRSRC: rdata_next = {29'h0000_0000, errsrc_reg};
        OFF_ENABLE: rdata_next = {28'h000_0000, enable_reg};
        OFF_PSEL_RTS: rdata_next = psel_rts_reg;
        OFF_PSEL_TX: rdata_next = psel_tx_reg;
        OFF_PSEL_CTS: rdata_next = psel_cts_reg;
        OFF_PSEL_RX: rdata_next = psel_rx_reg;
        OFF_RXDATA: rdata_next = {24'h00_0000, rxdata_reg};
        OFF_BAUD: rdata_next = {16'h0000, baud_reg};
        OFF_CONFIG: rdata_next = {30'h0000_0000, config_reg};
        default: ;
      endcase
    end
    if (wr_take)
    begin
      for (int i = 0; i < NUM_EV; i++)
      begin
        if (avs_req_i.address == EV_OFFS[i] && !avs_req_i.writedata[0])
          ev_clr[i] = 1'b1;
      end
      case (avs_req_i.address)
        OFF_ENABLE: enable_next = avs_req_i.writedata[ENABLE_W-1:0];
        OFF_PSEL_RTS: psel_rts_next = avs_req_i.writedata;
        OFF_PSEL_TX: psel_tx_next = avs_req_i.writedata;
        OFF_PSEL_CTS: psel_cts_next = avs_req_i.writedata;
        OFF_PSEL_RX: psel_rx_next = avs_req_i.writedata;
        OFF_BAUD: baud_next = avs_req_i.writedata[BAUD_W-1:0];
        OFF_CONFIG: config_next = avs_req_i.writedata[1:0];
        default: ;
      endcase
    end
  end

  // Events and error bits: a hardware set wins over a clear in the same cycle.
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_CTS] = en && cts_prev_reg && !cts_n;
    ev_set[EV_CLEAR_TO_SEND_LOST_EVENT] = en && !cts_prev_reg && cts_n;
    ev_set[EV_RXRDY] = rx_valid;
    ev_set[EV_TXDONE] = (txst_reg == TX_SEND) && (txst_next != TX_SEND)
      && (cnt_reg == baud_reg - 16'h0001) && (bit_reg == last_bit);
    err_set = {rx_valid && rx_ferr, rx_valid && rx_perr, rx_valid && ev_reg[EV_RXRDY]};
    ev_set[EV_ERROR] = |err_set;
    ev_next = ev_set | (ev_reg & ~ev_clr);
    errsrc_next = errsrc_reg;
    if (wr_take && avs_req_i.address == OFF_ERRSRC)
      errsrc_next = errsrc_reg & ~avs_req_i.writedata[2:0];
    errsrc_next = errsrc_next | err_set;
    rxdata_next = rx_valid ? rx_byte : rxdata_reg;
    cts_prev_next = cts_n;
    rx_on_next = rx_on_reg;
    if (wr_take && avs_req_i.writedata[0])
    begin
      if (avs_req_i.address == OFF_RX_BEGIN)
        rx_on_next = 1'b1;
      if (avs_req_i.address == OFF_RX_HALT || avs_req_i.address == OFF_SUSPEND)
        rx_on_next = 1'b0;
    end
    if (!en)
      rx_on_next = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  assign last_bit = par_en ? 4'(FRAME_MAX - 1) : 4'(FRAME_MAX - 2);

  // Sends pending bytes one frame at a time; pauses only between frames.
  always_comb
  begin
    txst_next = txst_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    pend_next = pend_reg;
    pdata_next = pdata_reg;
    susp_next = susp_reg;
    if (wr_take && avs_req_i.address == OFF_TXDATA && txst_reg != TX_OFF)
    begin
      pend_next = 1'b1;
      pdata_next = avs_req_i.writedata[DATA_BITS-1:0];
    end
    if (wr_take && avs_req_i.writedata[0] && avs_req_i.address == OFF_SUSPEND)
      susp_next = 1'b1;
    case (txst_reg)
      TX_OFF:
      begin
        pend_next = 1'b0;
        if (wr_take && avs_req_i.writedata[0] && avs_req_i.address == OFF_TX_BEGIN)
        begin
          txst_next = TX_IDLE;
          susp_next = 1'b0;
        end
      end
      TX_IDLE:
      begin
        if (susp_next || (wr_take && avs_req_i.writedata[0]
            && avs_req_i.address == OFF_TX_HALT))
          txst_next = TX_OFF;
        else if (pend_reg && cts_ok)
        begin
          txst_next = TX_SEND;
          pend_next = 1'b0;
          cnt_next = '0;
          bit_next = '0;
          if (par_en)
            sh_next = {1'b1, ^pdata_reg, pdata_reg, 1'b0};
          else
            sh_next = {2'b11, pdata_reg, 1'b0};
        end
      end
      TX_SEND:
      begin
        if (wr_take && avs_req_i.writedata[0] && avs_req_i.address == OFF_TX_HALT)
          txst_next = TX_OFF;
        else if (cnt_reg == baud_reg - 16'h0001)
        begin
          cnt_next = '0;
          sh_next = {1'b1, sh_reg[FRAME_MAX-1:1]};
          bit_next = bit_reg + 4'h1;
          if (bit_reg == last_bit)
            txst_next = susp_next ? TX_OFF : TX_IDLE;
        end
        else
          cnt_next = cnt_reg + 16'h0001;
      end
      default:
        txst_next = TX_OFF;
    endcase
    if (!en)
      txst_next = TX_OFF;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin routing.

  assign tx_line = (txst_reg == TX_SEND) ? sh_reg[0] : 1'b1;
  assign rts_n = !rx_on_reg;

  // Each pin is driven by the transmit or request signal whose select names it.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_pin
      logic tx_hit, rts_hit;
      assign tx_hit = en && pin_hit(psel_tx_reg, gp);
      assign rts_hit = en && pin_hit(psel_rts_reg, gp);
      assign poe_next[gp] = tx_hit || rts_hit;
      assign pout_next[gp] = tx_hit ? tx_line : (rts_hit ? rts_n : 1'b1);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // State registers; disabling never resets configuration, only reset does.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
      enable_reg <= '0;
      psel_rts_reg <= PSEL_RESET;
      psel_tx_reg <= PSEL_RESET;
      psel_cts_reg <= PSEL_RESET;
      psel_rx_reg <= PSEL_RESET;
      config_reg <= '0;
      baud_reg <= BAUD_DIV_RESET;
      ev_reg <= '0;
      errsrc_reg <= '0;
      rxdata_reg <= '0;
      rx_on_reg <= 1'b0;
      cts_prev_reg <= 1'b1;
      txst_reg <= TX_OFF;
      sh_reg <= '1;
      cnt_reg <= '0;
      bit_reg <= '0;
      pend_reg <= 1'b0;
      pdata_reg <= '0;
      susp_reg <= 1'b0;
      pout_reg <= '1;
      poe_reg <= '0;
    end
    else
    begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      enable_reg <= enable_next;
      psel_rts_reg <= psel_rts_next;
      psel_tx_reg <= psel_tx_next;
      psel_cts_reg <= psel_cts_next;
      psel_rx_reg <= psel_rx_next;
      config_reg <= config_next;
      baud_reg <= baud_next;
      ev_reg <= ev_next;
      errsrc_reg <= errsrc_next;
      rxdata_reg <= rxdata_next;
      rx_on_reg <= rx_on_next;
      cts_prev_reg <= cts_prev_next;
      txst_reg <= txst_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      pend_reg <= pend_next;
      pdata_reg <= pdata_next;
      susp_reg <= susp_next;
      pout_reg <= pout_next;
      poe_reg <= poe_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign pin_out_o = pout_reg;
  assign pin_oe_o = poe_reg;
endmodule

// File: design/uptfc_pkg.sv
// Package with register map, field layout, reset values and shared types of the transmit port.
package uptfc_pkg;

  // Register byte offsets on the bus.
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_RX_BEGIN = 12'h000;
  localparam logic [11:0] OFF_RX_HALT = 12'h004;
  localparam logic [11:0] OFF_TX_BEGIN = 12'h008;
  localparam logic [11:0] OFF_TX_HALT = 12'h00C;
  localparam logic [11:0] OFF_SUSPEND = 12'h01C;
  localparam logic [11:0] OFF_EV_CTS = 12'h100;
  localparam logic [11:0] OFF_EV_CLEAR_TO_SEND_LOST_EVENT = 12'h104;
  localparam logic [11:0] OFF_EV_RXRDY = 12'h108;
  localparam logic [11:0] OFF_EV_TXDONE = 12'h11C;
  localparam logic [11:0] OFF_EV_ERROR = 12'h124;
  localparam logic [11:0] OFF_ERRSRC = 12'h480;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_PSEL_RTS = 12'h508;
  localparam logic [11:0] OFF_PSEL_TX = 12'h50C;
  localparam logic [11:0] OFF_PSEL_CTS = 12'h510;
  localparam logic [11:0] OFF_PSEL_RX = 12'h514;
  localparam logic [11:0] OFF_RXDATA = 12'h518;
  localparam logic [11:0] OFF_TXDATA = 12'h51C;
  localparam logic [11:0] OFF_BAUD = 12'h524;
  localparam logic [11:0] OFF_CONFIG = 12'h56C;

  // Event registers in index order: gain, lost, rx ready, tx done, error.
  localparam int NUM_EV = 5;
  localparam int EV_CTS = 0;
  localparam int EV_CLEAR_TO_SEND_LOST_EVENT = 1;
  localparam int EV_RXRDY = 2;
  localparam int EV_TXDONE = 3;
  localparam int EV_ERROR = 4;
  localparam logic [NUM_EV-1:0][11:0] EV_OFFS = {OFF_EV_ERROR, OFF_EV_TXDONE,
    OFF_EV_RXRDY, OFF_EV_CLEAR_TO_SEND_LOST_EVENT, OFF_EV_CTS};

  // Pin select layout and reset value.
  localparam logic [31:0] PSEL_RESET = 32'hFFFF_FFFF;
  localparam int PSEL_CONNECT_BIT = 31;
  localparam int PSEL_PIN_W = 5;

  // Enable field and its enabling value.
  localparam int ENABLE_W = 4;
  localparam logic [3:0] ENABLE_ON = 4'h4;

  // Configuration and error source bits.
  localparam int CFG_HWFC_BIT = 0;
  localparam int CFG_PARITY_BIT = 1;
  localparam int ERR_OVERRUN_BIT = 0;
  localparam int ERR_PARITY_BIT = 1;
  localparam int ERR_FRAME_BIT = 2;

  // Character layout and default bit timing.
  localparam int DATA_BITS = 8;
  localparam int FRAME_MAX = 11;
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_W = 16;
  localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / BAUD_DEFAULT);

  // Bus request carried as one bundle.
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [31:0] writedata;
  } uptfc_avreq_t;

  // Transmitter states.
  typedef enum {TX_OFF, TX_IDLE, TX_SEND} uptfc_txst_t;

  // Receiver states.
  typedef enum {RX_IDLE, RX_BITS} uptfc_rxst_t;

endpackage

// File: design/uptfc_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ns
module uptfc_sync #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // The first stage is read by the second stage only.
  always_comb
  begin
    meta_next = d_i;
    q_next = meta_reg;
  end

  // Both stages reset to the idle high level of a serial line.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '1;
      q_reg <= '1;
    end
    else
    begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule

// File: design/uptfc_rx.sv
// Receive shifter with even parity check and stop bit check.
`timescale 1ns/1ns
module uptfc_rx
  import uptfc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic line_i,
  input wire logic parity_en_i,
  input wire logic [BAUD_W-1:0] baud_div_i,
  output logic [DATA_BITS-1:0] byte_o,
  output logic byte_valid_o,
  output logic parity_err_o,
  output logic frame_err_o
);
  uptfc_rxst_t st_reg, st_next;
  logic [BAUD_W-1:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [FRAME_MAX-1:0] sh_reg, sh_next;
  logic [DATA_BITS-1:0] byte_reg, byte_next;
  logic valid_reg, valid_next;
  logic perr_reg, perr_next;
  logic ferr_reg, ferr_next;
  logic [3:0] last_bit;

  // Samples mid-bit; the collected frame is left aligned, stop bit in the top bit, when the stop bit arrives.
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    byte_next = byte_reg;
    valid_next = 1'b0;
    perr_next = 1'b0;
    ferr_next = 1'b0;
    last_bit = parity_en_i ? 4'(FRAME_MAX - 1) : 4'(FRAME_MAX - 2);
    case (st_reg)
      RX_IDLE:
      begin
        if (run_i && !line_i)
        begin
          st_next = RX_BITS;
          cnt_next = baud_div_i >> 1;
          bit_next = 4'h0;
        end
      end
      RX_BITS:
      begin
        if (cnt_reg == '0)
        begin
          sh_next = {line_i, sh_reg[FRAME_MAX-1:1]};
          cnt_next = baud_div_i - 16'h0001;
          bit_next = bit_reg + 4'h1;
          if (bit_reg == last_bit)
          begin
            st_next = RX_IDLE;
            valid_next = 1'b1;
            byte_next = parity_en_i ? sh_next[8:1] : sh_next[9:2];
            perr_next = parity_en_i && (^sh_next[9:1]);
            ferr_next = !sh_next[FRAME_MAX-1];
          end
        end
        else
        begin
          cnt_next = cnt_reg - 16'h0001;
        end
        if (!run_i)
        begin
          st_next = RX_IDLE;
        end
      end
      default:
      begin
        st_next = RX_IDLE;
      end
    endcase
  end

  // Registers of the receiver.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= RX_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      sh_reg <= '1;
      byte_reg <= '0;
      valid_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      byte_reg <= byte_next;
      valid_reg <= valid_next;
      perr_reg <= perr_next;
      ferr_reg <= ferr_next;
    end
  end

  assign byte_o = byte_reg;
  assign byte_valid_o = valid_reg;
  assign parity_err_o = perr_reg;
  assign frame_err_o = ferr_reg;
endmodule

// File: verification/uptfc_assertions.sv
// Checker of bus handshake, pin release and transmit line idle level.
`timescale 1ns/1ns
module uptfc_assertions
  import uptfc_pkg::*;
#(
  parameter int NUM_PINS = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input uptfc_pkg::uptfc_avreq_t avs_req_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [NUM_PINS-1:0] pin_in_i,
  input wire logic [NUM_PINS-1:0] pin_out_o,
  input wire logic [NUM_PINS-1:0] pin_oe_o
);
  logic en_reg, en_next, run_reg, run_next, wr_ok;
  logic [31:0] sel_reg, sel_next;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // A write lands at the edge where waitrequest is seen low.
  assign wr_ok = avs_req_i.write && !avs_waitrequest_o;
  // Shadow of enable, transmit pin select and started state.
  always_comb
  begin
    en_next = en_reg;
    sel_next = sel_reg;
    run_next = run_reg;
    if (wr_ok && avs_req_i.address == OFF_ENABLE)
      en_next = avs_req_i.writedata[3:0] == ENABLE_ON;
    if (wr_ok && avs_req_i.address == OFF_PSEL_TX)
      sel_next = avs_req_i.writedata;
    if (wr_ok && en_reg && avs_req_i.address == OFF_TX_BEGIN && avs_req_i.writedata[0])
      run_next = 1'b1;
    if (wr_ok && avs_req_i.address == OFF_TX_HALT && avs_req_i.writedata[0])
      run_next = 1'b0;
    run_next = run_next && en_next;
  end
  // Registers of the shadow state.
  always_ff @(posedge clk_i)
  begin
    en_reg <= rst_i ? 1'b0 : en_next;
    run_reg <= rst_i ? 1'b0 : run_next;
    sel_reg <= rst_i ? PSEL_RESET : sel_next;
  end
  ////////////////////////////////////////////////////////////////////////////
  // A taken request and its one-cycle answer.
  sequence seq_req;
    (avs_req_i.read || avs_req_i.write) && avs_waitrequest_o;
  endsequence
  sequence seq_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  chk_wait_one: assert property (seq_req |=> seq_ans)
    else $error("request not answered after one wait cycle");
  chk_answer_cause: assert property (!avs_waitrequest_o |->
    $past(avs_req_i.read || avs_req_i.write))
    else $error("answer without a request");
  chk_reset_idle: assert property ($fell(rst_i) |-> avs_waitrequest_o &&
    pin_oe_o == '0 && pin_out_o == '1)
    else $error("outputs not idle after reset");
  chk_unmapped_zero: assert property ((avs_req_i.read &&
    avs_req_i.address == 12'h200) and seq_req |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_read_hold: assert property (!$past(rst_i) && $changed(avs_readdata_o) |->
    !avs_waitrequest_o)
    else $error("read data changed outside an answer");
  chk_pins_released: assert property ((!en_reg) [*3] |-> pin_oe_o == '0)
    else $error("pin driven while disabled");
  chk_tx_drive: assert property ((en_reg && !sel_reg[PSEL_CONNECT_BIT]) [*3] |->
    pin_oe_o[sel_reg[4:0]])
    else $error("selected transmit pin not driven");
  chk_tx_idle: assert property ((en_reg && !run_reg &&
    !sel_reg[PSEL_CONNECT_BIT]) [*3] |-> pin_out_o[sel_reg[4:0]])
    else $error("transmit line not idle high");
endmodule
bind uptfc_top uptfc_assertions #(.NUM_PINS(NUM_PINS)) u_uptfc_assertions (.clk_i(clk_i),
  .rst_i(rst_i), .avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o));

// File: verification/uptfc_far_end.sv
// Model of the far serial device: grants clear-to-send and decodes frames.
`timescale 1ns/1ns
module uptfc_far_end #(
  parameter int BIT = 4
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic parity_i,
  input wire logic hold_i,
  output logic cts_n_o,
  output logic [8:0] word_o,
  output logic stop_o,
  output int frames_o
);
  // Clear-to-send is driven low to grant and high to pause.
  assign cts_n_o = hold_i;
  // Each frame is sampled mid-bit: data lowest bit first, parity, then stop.
  initial
  begin
    frames_o = 0;
    forever
    begin
      @(negedge line_i);
      word_o = 9'h0;
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < (parity_i ? 9 : 8); i++)
      begin
        repeat (BIT) @(posedge clk_i);
        word_o[i] = line_i;
      end
      repeat (BIT) @(posedge clk_i);
      stop_o = line_i;
      frames_o++;
    end
  end
endmodule

// File: verification/uptfc_tb_top.sv
// Self-checking bench of the transmit port over its bus and pins.
`timescale 1ns/1ns
module uptfc_tb_top;
  import uptfc_pkg::*;
  logic clk_i, rst_i, wt, hold, par, cts_n, stop;
  uptfc_avreq_t req;
  logic [31:0] rdat, pin_in, pin_out, pin_oe, ext;
  logic [8:0] word;
  int frames, errors, checked;
  int cyc = 0;
  uptfc_top #(.NUM_PINS(32)) u_uptfc_top (.clk_i(clk_i), .rst_i(rst_i), .avs_req_i(req),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe));
  uptfc_far_end #(.BIT(4)) u_uptfc_far_end (.clk_i(clk_i), .line_i(pin_in[3]),
    .parity_i(par), .hold_i(hold), .cts_n_o(cts_n), .word_o(word), .stop_o(stop),
    .frames_o(frames));
  // Undriven pins are pulled up; clear-to-send sits on pin 5.
  assign ext = {26'h3FF_FFFF, cts_n, 5'h1F};
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  // Clock of 20 ns and a hang limit.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One bus access, held until waitrequest is seen low.
  task automatic acc(input logic rd, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk_i);
    req <= {rd, !rd, a, d};
    do @(posedge clk_i); while (wt !== 1'b0);
    q = rdat;
    req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b0, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b1, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Waits for a frame, checks it and the done event, then clears the event.
  task automatic fin(input int n, input logic [8:0] e);
    logic [31:0] q;
    for (int k = 0; k < 400 && frames < n; k++) cycles(1);
    chk({23'h0, word}, {23'h0, e});
    chk({31'h0, stop}, 32'h1);
    q = 32'h0;
    for (int k = 0; k < 40 && q[0] !== 1'b1; k++) acc(1'b1, OFF_EV_TXDONE, 32'h0, q);
    chk(q, 32'h1);
    wr(OFF_EV_TXDONE, 32'h0);
  endtask
  task automatic send(input logic [7:0] b, input logic [8:0] e);
    int n;
    n = frames + 1;
    wr(OFF_TXDATA, {24'h0, b});
    fin(n, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc(OFF_PSEL_TX, PSEL_RESET);
    rc(12'h200, 32'h0);
    chk(pin_oe, 32'h0);
  endtask
  // Pins are chosen while disabled; a byte before the start task is dropped.
  task automatic t_setup;
    int n;
    wr(OFF_BAUD, 32'h4);
    wr(OFF_PSEL_RTS, 32'h4);
    wr(OFF_PSEL_TX, 32'h3);
    wr(OFF_PSEL_CTS, 32'h5);
    wr(OFF_PSEL_RX, 32'h6);
    wr(OFF_ENABLE, {28'h0, ENABLE_ON});
    cycles(4);
    chk({30'h0, pin_oe[4:3]}, 32'h3);
    chk({30'h0, pin_out[4:3]}, 32'h3);
    n = frames;
    wr(OFF_TXDATA, 32'h3C);
    cycles(80);
    chk(frames, n);
  endtask
  task automatic t_send;
    wr(OFF_TX_BEGIN, 32'h1);
    send(8'h55, 9'h055);
    send(8'hA3, 9'h0A3);
    par = 1'b1;
    wr(OFF_CONFIG, 32'h2);
    send(8'h07, 9'h107);
    send(8'h03, 9'h003);
    par = 1'b0;
  endtask
  // Pause while clear-to-send is high, a byte finished across a pause.
  task automatic t_flow;
    int n;
    wr(OFF_CONFIG, 32'h1);
    hold <= 1'b1;
    cycles(8);
    rc(OFF_EV_CLEAR_TO_SEND_LOST_EVENT, 32'h1);
    wr(OFF_EV_CTS, 32'h0);
    n = frames + 1;
    wr(OFF_TXDATA, 32'h5A);
    cycles(80);
    chk(frames, n - 1);
    hold <= 1'b0;
    fin(n, 9'h05A);
    rc(OFF_EV_CTS, 32'h1);
    n = frames + 1;
    wr(OFF_TXDATA, 32'hC3);
    for (int k = 0; k < 50 && pin_out[3] !== 1'b0; k++) cycles(1);
    hold <= 1'b1;
    fin(n, 9'h0C3);
    wr(OFF_CONFIG, 32'h0);
    send(8'h81, 9'h081);
    hold <= 1'b0;
  endtask
  // Suspend during a byte, stop in mid-frame, then release and keep the pin selects.
  task automatic t_halt_off;
    int n;
    wr(OFF_RX_BEGIN, 32'h1);
    cycles(2);
    chk({31'h0, pin_out[4]}, 32'h0);
    n = frames + 1;
    wr(OFF_TXDATA, 32'h96);
    for (int k = 0; k < 50 && pin_out[3] !== 1'b0; k++) cycles(1);
    wr(OFF_SUSPEND, 32'h1);
    fin(n, 9'h096);
    chk({31'h0, pin_out[4]}, 32'h1);
    wr(OFF_TXDATA, 32'h11);
    cycles(60);
    chk(frames, n);
    wr(OFF_TX_BEGIN, 32'h1);
    wr(OFF_TXDATA, 32'h0);
    for (int k = 0; k < 50 && pin_out[3] !== 1'b0; k++) cycles(1);
    cycles(6);
    wr(OFF_TX_HALT, 32'h1);
    cycles(2);
    chk({31'h0, pin_out[3]}, 32'h1);
    cycles(60);
    wr(OFF_ENABLE, 32'h0);
    cycles(4);
    chk(pin_oe, 32'h0);
    rc(OFF_PSEL_TX, 32'h3);
    wr(OFF_PSEL_TX, PSEL_RESET);
    wr(OFF_ENABLE, {28'h0, ENABLE_ON});
    cycles(4);
    chk({30'h0, pin_oe[4:3]}, 32'h2);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence after a reset of 16 cycles.
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    hold = 1'b0;
    par = 1'b0;
    errors = 0;
    checked = 0;
    cycles(16);
    rst_i <= 1'b0;
    t_reset();
    t_setup();
    t_send();
    t_flow();
    t_halt_off();
    end_of_test();
  end
endmodule
